// ==== rtl/thbp_consts.vh ====
`ifndef THBP_CONSTS_VH
`define THBP_CONSTS_VH

`define THBP_DW            16
`define THBP_LOW_W         8
`define THBP_NCH           5
`define THBP_GATE_LSB      8
`define THBP_HIGH_LSB      8
`define THBP_AUX_HOLD_LSB  13
`define THBP_PTR_W         8
`define THBP_CMD_W         8
`define THBP_WIDTH_BIT     14
`define THBP_PTR_GROUP_LSB 0
`define THBP_LDPTR_MASK    8'he0
`define THBP_LDPTR_CODE    8'h00
`define THBP_MM_PTR        8'h17
`define THBP_STATUS_PTR    8'h1f
`define THBP_STATUS_RST    16'h0000
`define THBP_MM_RST        16'h0000
`define THBP_BYTE_ZERO     8'h00
`define THBP_NREG          32
`define THBP_IDX_W         5

`endif

// ==== rtl/thbp_sync.v ====
`timescale 1ns/1ps
module thbp_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;

  // A bit changes only once the second and third stages agree
  always @(posedge clk) begin
    if (rst) begin
      s1_reg <= {W{1'b1}};
      s2_reg <= {W{1'b1}};
      s3_reg <= {W{1'b1}};
      dout   <= {W{1'b1}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout   <= (s2_reg == s3_reg) ? s3_reg : dout;
    end
  end
endmodule

// ==== rtl/thbp_port.v ====
// Summary of operation
// - Read strobe counts only under chip select
// - Read source from port and data pointer
// - Write strobe counts only under chip select
// - Write destination from port and pointer
// - Control write always loads command; pointer-load codes also load data pointer
// - Control read returns status register
// - Data port reaches other registers via pointer
// - Width bit picks 16-bit or 8-bit bus
// - Strobes ignored while chip select inactive
// - Drive bus only during enabled read
// - Reset selects 8-bit bus on low lines
// - In 8-bit mode a low auxiliary gate line disables counter gating
`timescale 1ns/1ps
`include "thbp_consts.vh"
module thbp_port (
  input  wire                     clk,
  input  wire                     rst,
  input  wire                     cs_n,
  input  wire                     rd_n,
  input  wire                     wr_n,
  input  wire                     ctl_sel,
  input  wire [`THBP_DW-1:0]      db_in,
  output reg  [`THBP_DW-1:0]      db_out,
  output wire [`THBP_DW-1:0]      db_oe,
  input  wire [`THBP_DW-1:0]      status_in,
  output reg  [`THBP_CMD_W-1:0]   cmd_data,
  output reg                      cmd_strobe,
  output reg  [`THBP_PTR_W-1:0]   data_ptr,
  output wire                     bus_width_bit,
  output wire [`THBP_NCH-1:0]     aux_gate_enable,
  output reg  [`THBP_DW-1:0]      reg_wdata,
  output reg  [`THBP_IDX_W-1:0]   reg_windex,
  output reg                      reg_wstrobe,
  output reg                      byte_toggle
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_READ  = 2'b01;
  localparam ST_WRITE = 2'b10;

  wire [`THBP_DW-1:0] db_s;
  wire                cs_s;
  wire                rd_s;
  wire                wr_s;
  wire                cd_s;
  reg  [1:0]          state_reg;
  reg  [1:0]          state_next;
  reg  [`THBP_DW-1:0] wlatch_reg;
  reg                 wctl_reg;
  reg  [`THBP_DW-1:0] mm_reg;
  reg                 hi_byte_reg;
  reg  [`THBP_DW-1:0] regs [0:`THBP_NREG-1];
  reg  [`THBP_DW-1:0] rd_word;
  reg                 drive;
  integer             i;

  // Every host pin is asynchronous to clk
  thbp_sync #(.W(`THBP_DW + 4)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({db_in, cs_n, rd_n, wr_n, ctl_sel}),
    .dout ({db_s, cs_s, rd_s, wr_s, cd_s})
  );

  assign bus_width_bit = mm_reg[`THBP_WIDTH_BIT];
  // In 8-bit mode the upper lines act as gate enables; 16-bit mode leaves gating alone
  assign aux_gate_enable = bus_width_bit ? {`THBP_NCH{1'b1}} :
                           db_s[`THBP_GATE_LSB +: `THBP_NCH];

  // Output enable follows the pins directly so the bus floats as soon as CS rises
  always @* begin
    drive = (state_reg == ST_READ) && !cs_n && !rd_n;
  end
  assign db_oe = !drive ? {`THBP_DW{1'b0}} :
                 bus_width_bit ? {`THBP_DW{1'b1}} :
                 {{(`THBP_DW-`THBP_LOW_W){1'b0}}, {`THBP_LOW_W{1'b1}}};

  // Source selection by port and pointer
  always @* begin
    if (cd_s)
      rd_word = status_in;
    else if (data_ptr == `THBP_MM_PTR)
      rd_word = mm_reg;
    else
      rd_word = regs[data_ptr[`THBP_IDX_W-1:0]];
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!cs_s && !rd_s)
          state_next = ST_READ;
        else if (!cs_s && !wr_s)
          state_next = ST_WRITE;
      end
      ST_READ: begin
        if (rd_s || cs_s)
          state_next = ST_IDLE;
      end
      ST_WRITE: begin
        if (wr_s || cs_s)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      wlatch_reg  <= `THBP_STATUS_RST;
      wctl_reg    <= 1'b0;
      mm_reg      <= `THBP_MM_RST;
      hi_byte_reg <= 1'b0;
      data_ptr    <= `THBP_STATUS_PTR;
      cmd_data    <= `THBP_BYTE_ZERO;
      cmd_strobe  <= 1'b0;
      db_out      <= `THBP_STATUS_RST;
      reg_wdata   <= `THBP_STATUS_RST;
      reg_windex  <= {`THBP_IDX_W{1'b0}};
      reg_wstrobe <= 1'b0;
      byte_toggle <= 1'b0;
      for (i = 0; i < `THBP_NREG; i = i + 1)
        regs[i] <= `THBP_STATUS_RST;
    end else begin
      state_reg   <= state_next;
      cmd_strobe  <= 1'b0;
      reg_wstrobe <= 1'b0;
      byte_toggle <= 1'b0;
      if (state_reg == ST_IDLE && state_next == ST_READ) begin
        if (bus_width_bit || cd_s)
          db_out <= rd_word;
        else
          db_out <= {`THBP_BYTE_ZERO,
                     hi_byte_reg ? rd_word[`THBP_HIGH_LSB +: `THBP_LOW_W]
                                 : rd_word[`THBP_LOW_W-1:0]};
      end
      // Track the data while the strobe is low; the last value seen is committed
      if (state_reg == ST_WRITE) begin
        wlatch_reg <= db_s;
        wctl_reg   <= cd_s;
      end
      // A write aborted by CS rising before WR is dropped
      if (state_reg == ST_WRITE && wr_s && !cs_s) begin
        if (wctl_reg) begin
          cmd_data   <= wlatch_reg[`THBP_LOW_W-1:0];
          cmd_strobe <= 1'b1;
          if ((wlatch_reg[`THBP_LOW_W-1:0] & `THBP_LDPTR_MASK) == `THBP_LDPTR_CODE) begin
            data_ptr    <= wlatch_reg[`THBP_PTR_W-1:0];
            hi_byte_reg <= 1'b0;
          end
        end else begin
          if (bus_width_bit || hi_byte_reg) begin
            reg_wdata <= bus_width_bit ? wlatch_reg :
                         {wlatch_reg[`THBP_LOW_W-1:0], regs[data_ptr[`THBP_IDX_W-1:0]]
                                                          [`THBP_LOW_W-1:0]};
            reg_windex  <= data_ptr[`THBP_IDX_W-1:0];
            reg_wstrobe <= 1'b1;
            if (data_ptr == `THBP_MM_PTR)
              mm_reg <= bus_width_bit ? wlatch_reg :
                        {wlatch_reg[`THBP_LOW_W-1:0], mm_reg[`THBP_LOW_W-1:0]};
            else if (data_ptr != `THBP_STATUS_PTR)
              regs[data_ptr[`THBP_IDX_W-1:0]] <= bus_width_bit ? wlatch_reg :
                {wlatch_reg[`THBP_LOW_W-1:0], regs[data_ptr[`THBP_IDX_W-1:0]]
                                                  [`THBP_LOW_W-1:0]};
          end else if (data_ptr == `THBP_MM_PTR)
            mm_reg[`THBP_LOW_W-1:0] <= wlatch_reg[`THBP_LOW_W-1:0];
          else if (data_ptr != `THBP_STATUS_PTR)
            regs[data_ptr[`THBP_IDX_W-1:0]][`THBP_LOW_W-1:0] <= wlatch_reg[`THBP_LOW_W-1:0];
          if (!bus_width_bit) begin
            hi_byte_reg <= !hi_byte_reg;
            byte_toggle <= 1'b1;
          end
        end
      end
      // Low byte read first in 8-bit mode; the byte pointer toggles after each data-port transfer
      if (state_reg == ST_READ && (rd_s || cs_s) && !cd_s && !bus_width_bit) begin
        hi_byte_reg <= !hi_byte_reg;
        byte_toggle <= 1'b1;
      end
    end
  end
endmodule

// ==== dv/thbp_port_assertions.sv ====
`timescale 1ns/1ps
module thbp_checker (
  input logic        clk,
  input logic        rst,
  input logic        cs_n,
  input logic        rd_n,
  input logic        wr_n,
  input logic [15:0] db_oe,
  input logic        cmd_strobe,
  input logic        reg_wstrobe,
  input logic [7:0]  data_ptr,
  input logic        bus_width_bit,
  input logic [4:0]  aux_gate_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet; cs_n [*8]; endsequence
  sequence s_wide; bus_width_bit [*2]; endsequence
  AST_CS_FLOAT: assert property (cs_n |-> db_oe == 16'h0000)
    else $error("bus driven while deselected");
  AST_RD_FLOAT: assert property (rd_n |-> db_oe == 16'h0000)
    else $error("bus driven outside read");
  // Strobes pass a synchroniser, so drive cannot start within three edges
  AST_RD_SYNC: assert property (db_oe != 0 |-> !$past(rd_n, 3) && !$past(cs_n, 3))
    else $error("drive before read taken");
  AST_NARROW: assert property (!bus_width_bit |-> db_oe[15:8] == 8'h00)
    else $error("upper lines driven in narrow mode");
  AST_WIDE_GATE: assert property (s_wide |-> aux_gate_enable == 5'h1f)
    else $error("gating held off in wide mode");
  AST_RESET: assert property (disable iff (1'b0) rst |=> data_ptr == 8'h1f && !bus_width_bit)
    else $error("reset state wrong");
  AST_TRAIL: assert property ((cmd_strobe || reg_wstrobe) |-> wr_n && $past(wr_n, 2))
    else $error("commit before write strobe released");
  AST_QUIET: assert property (s_quiet |-> !cmd_strobe && !reg_wstrobe)
    else $error("commit while deselected");
endmodule

bind thbp_port thbp_checker thbp_checker_inst (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .db_oe(db_oe), .cmd_strobe(cmd_strobe), .reg_wstrobe(reg_wstrobe),
  .data_ptr(data_ptr), .bus_width_bit(bus_width_bit), .aux_gate_enable(aux_gate_enable));

// ==== dv/thbp_host.sv ====
`timescale 1ns/1ps
module thbp_host (
  input  wire  logic        clk,
  input  wire  logic [15:0] bus,
  output logic              cs_n,
  output logic              rd_n,
  output logic              wr_n,
  output logic              ctl_sel,
  output wire  logic [15:0] hd
);
  logic        w16 = 0;
  logic [4:0]  gv = 5'h1f;
  logic [15:0] d = 16'h0000;
  logic        on = 0;
  // Released lines show the inverse so a stale value never passes for read data
  assign hd[7:0] = on ? d[7:0] : ~d[7:0];
  assign hd[15:8] = w16 ? (on ? d[15:8] : ~d[15:8]) : {3'b111, gv};
  initial begin
    cs_n = 1;
    rd_n = 1;
    wr_n = 1;
    ctl_sel = 0;
  end
  task automatic acc(input logic sel, rd, ctl, input logic [15:0] v, output logic [15:0] q);
    @(posedge clk);
    #1 cs_n = !sel;
    ctl_sel = ctl;
    d = v;
    on = !rd;
    rd_n = !rd;
    wr_n = rd;
    repeat (8) @(posedge clk);
    q = bus;
    // Strobe rises first; chip select and data stay until the commit is seen
    #1 rd_n = 1;
    wr_n = 1;
    repeat (8) @(posedge clk);
    #1 cs_n = 1;
    on = 0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        clk = 0;
  logic        rst = 1;
  logic [15:0] status_in = 16'ha55a;
  logic [15:0] hd, db_out, db_oe, q, reg_wdata, wd_seen;
  logic        cs_n, rd_n, wr_n, ctl_sel, cmd_strobe, reg_wstrobe, bus_width_bit, byte_toggle;
  int          n_tog = 0;
  logic [7:0]  cmd_data, data_ptr;
  logic [4:0]  aux_gate_enable, reg_windex;
  int          n_mismatch = 0, samples_checked = 0, n_cmd = 0, n_wr = 0;
  wire  [15:0] db_in = (db_oe & db_out) | (~db_oe & hd);
  initial forever #10 clk = ~clk;
  thbp_host host_inst (.clk(clk), .bus(db_in), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .ctl_sel(ctl_sel), .hd(hd));
  thbp_port thbp_port_inst (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .ctl_sel(ctl_sel), .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .status_in(status_in),
    .cmd_data(cmd_data), .cmd_strobe(cmd_strobe), .data_ptr(data_ptr),
    .bus_width_bit(bus_width_bit), .aux_gate_enable(aux_gate_enable), .reg_wdata(reg_wdata),
    .reg_windex(reg_windex), .reg_wstrobe(reg_wstrobe), .byte_toggle(byte_toggle));
  always @(posedge clk) begin
    if (byte_toggle) n_tog++;
    if (cmd_strobe) n_cmd++;
    if (reg_wstrobe) begin
      n_wr++;
      wd_seen = reg_wdata;
    end
  end
  task automatic chk(input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_ctl;
    host_inst.acc(1, 0, 1, 16'h0005, q);
    chk(data_ptr, 8'h05);
    host_inst.acc(0, 0, 1, 16'h0007, q);
    chk(data_ptr, 8'h05);
    host_inst.acc(1, 0, 1, 16'h0020, q);
    chk(cmd_data, 8'h20);
    chk(n_cmd[15:0], 16'h0002);
    host_inst.acc(1, 1, 1, 16'h0000, q);
    chk(q[7:0], 8'h5a);
  endtask
  task automatic t_data;
    host_inst.acc(1, 0, 1, 16'h0001, q);
    host_inst.acc(1, 0, 0, 16'h0034, q);
    chk(n_wr[15:0], 16'h0000);
    host_inst.acc(1, 0, 0, 16'h0012, q);
    chk(wd_seen, 16'h1234);
    chk(reg_windex, 16'h0001);
    chk(n_tog[15:0], 16'h0002);
    #1 host_inst.gv = 5'h15;
    repeat (6) @(posedge clk);
    chk(aux_gate_enable, 5'h15);
    #1 host_inst.gv = 5'h1f;
    host_inst.acc(1, 0, 1, 16'h0017, q);
    host_inst.acc(1, 0, 0, 16'h0000, q);
    host_inst.acc(1, 0, 0, 16'h0040, q);
    chk(bus_width_bit, 1'b1);
    #1 host_inst.w16 = 1;
    host_inst.acc(1, 1, 1, 16'h0000, q);
    chk(q, 16'ha55a);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    repeat (5) @(posedge clk);
    chk(data_ptr, 8'h1f);
    chk(db_oe, 16'h0000);
    t_ctl;
    t_data;
    report_and_stop;
  end
endmodule
